// [test_vpm_slice.sv]
`timescale 1ns/100ps
module test_vpm_slice import vpm_pkg::*;;
	logic clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, op_valid = 0, slow = 0, rd_d = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
	logic [63:0] cascade_in = 64'h0, cascade_out;
	logic [73:0] result, q[$], qr[$];
	logic op_ready, res_valid, res_ready;
	logic [26:0] c0 [8];
	logic [17:0] c1 [8];
	logic [3:0] modes [10] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'he, 4'h1, 4'h3, 4'hb, 4'h8, 4'hd};
	logic [3:0] mode;
	vpm_op_s op_data = '0, o;
	int n_fail = 0, checks = 0, seed = 86;
	vpm_slice vpm_slice_i (.*);
	vpm_sink vpm_sink_i (.*);
	always #12.5 clk = ~clk;
	task automatic chk(input logic [73:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		if (n_fail == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	function automatic logic [73:0] calc(vpm_op_s x);
		logic signed [18:0] s0, s1;
		logic signed [36:0] p0, p1;
		logic signed [26:0] h;
		logic signed [73:0] r;
		s0 = $signed(x.a0) + (mode[1] ? $signed(x.b0) : 18'sd0);
		s1 = $signed(x.a1) + (mode[1] ? $signed(x.b1) : 18'sd0);
		h = $signed({x.a1[8:0], x.a0}) + (mode[1] ? $signed({x.b1[8:0], x.b0}) : 27'sd0);
		p0 = s0 * $signed(c0[x.sel][17:0]);
		p1 = s1 * $signed(c1[x.sel]);
		r = mode[0] ? h * $signed(c0[x.sel]) : mode[2] ? p0 + p1 : $signed({p1, p0});
		if (mode[3] && (mode[0] || mode[2]))
			r = r + $signed(cascade_in);
		return r;
	endfunction
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		if (w)
			reg_write <= 1'b1;
		else begin
			reg_read <= 1'b1;
			qr.push_back(74'(d));
		end
		@(posedge clk);
		reg_write <= 1'b0;
		reg_read <= 1'b0;
	endtask
	always @(posedge clk) begin
		rd_d <= reg_read;
		if (rd_d)
			chk(74'(reg_rdata), qr.pop_front());
		if (res_valid && res_ready)
			chk(result, q.pop_front());
	end
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		bus(0, 8'h00, 32'h0);
		for (int i = 0; i < 8; i++) begin
			// index 0 holds the most negative 18-bit value, sign-extended in the 27-bit bank
			v = i ? $random(seed) : 32'hfffe0000;
			c0[i] = v[26:0];
			c1[i] = v[17:0];
			bus(1, 8'h40 + 8'(4 * i), v);
			bus(1, 8'h60 + 8'(4 * i), v);
			bus(0, 8'h40 + 8'(4 * i), {5'h0, c0[i]});
			bus(0, 8'h60 + 8'(4 * i), {14'h0, c1[i]});
		end
		bus(1, 8'h10, 32'hffffffff);
		bus(0, 8'h10, 32'h0);
		foreach (modes[k]) begin
			bus(1, 8'h00, {28'h0, modes[k]});
			bus(0, 8'h00, {28'h0, modes[k]});
			mode = modes[k];
			slow <= modes[k][1];
			cascade_in <= {$random(seed), $random(seed)};
			@(posedge clk);
			for (int i = 0; i < 24; i++) begin
				o = i ? 75'({$random(seed), $random(seed), $random(seed)}) : {{4{18'h20000}}, 3'h0};
				o.sel = 3'(i);
				op_data <= o;
				op_valid <= 1'b1;
				q.push_back(calc(o));
				@(posedge clk);
				while (!op_ready)
					@(posedge clk);
			end
			op_valid <= 1'b0;
			while (q.size() != 0)
				@(posedge clk);
			bus(0, 8'h04, {16'(24 * (k + 1)), 16'h0});
		end
		report_and_stop();
	end
	initial begin
		#500000;
		n_fail++;
		report_and_stop();
	end
endmodule

// [vpm_cfg.svh]
`ifndef VPM_CFG_SVH
`define VPM_CFG_SVH
// datapath widths
`define VPM_NW 18
`define VPM_SUMW 19
`define VPM_NPW 37
`define VPM_HW 27
`define VPM_HPW 54
`define VPM_RESW 74
`define VPM_CASW 64
`define VPM_SELW 3
`define VPM_NCOEF 8
`define VPM_FIFO_DEPTH 16
// register bus
`define VPM_AW 8
`define VPM_DW 32
`define VPM_OFF_CTRL 8'h00
`define VPM_OFF_STATUS 8'h04
`define VPM_OFF_COEF0 8'h40
`define VPM_OFF_COEF1 8'h60
`define VPM_COEF_MASK 8'he0
// control fields and reset value
`define VPM_CTRL_HP 0
`define VPM_CTRL_PREADD 1
`define VPM_CTRL_SUM 2
`define VPM_CTRL_CASC 3
`define VPM_CTRL_RST 4'h0
// status fields
`define VPM_ST_LVL_LO 0
`define VPM_ST_OUTV 8
`define VPM_ST_CNT_LO 16
`endif

// [vpm_pkg.sv]
`include "vpm_cfg.svh"
package vpm_pkg;
	typedef enum logic [1:0] {
		VPM_NARROW = 2'b01,
		VPM_HIGH = 2'b10
	} vpm_mode_e;
	typedef struct packed {
		logic [`VPM_NW-1:0] a1;
		logic [`VPM_NW-1:0] b1;
		logic [`VPM_NW-1:0] a0;
		logic [`VPM_NW-1:0] b0;
		logic [`VPM_SELW-1:0] sel;
	} vpm_op_s;
	typedef struct packed {
		logic casc_en;
		logic sum_en;
		logic preadd_en;
		logic high_prec;
	} vpm_ctrl_s;
	typedef struct packed {
		logic [`VPM_RESW-1:0] result;
		logic [`VPM_CASW-1:0] cascade;
	} vpm_res_s;
endpackage

// [vpm_sink.sv]
`timescale 1ns/100ps
module vpm_sink (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic slow,
	output logic res_ready
);
	logic [1:0] cnt_r;
	// slow takes one result in four so the queue backs up until refused
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 2'h0;
			res_ready <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 2'h1;
			res_ready <= !slow || &cnt_r;
		end
	end
endmodule

// [vpm_slice.sv]
// Notes on behaviour
// - only two precisions: dual narrow 18-bit, or one signed 27x27 multiply
// - narrow mode: each pre-adder input takes a whole signed 18-bit operand
// - pre-adder is two 19-bit adders narrow, one 27-bit adder high-precision
// - enabled pre-adder sums two samples, product uses one shared coefficient
// - narrow multipliers are 18x19, the 19-bit side holds the full sum
// - narrow mode: two 18-bit banks of eight coefficients each
// - high-precision mode: one 27-bit bank of eight coefficients
// - a 3-bit index picks the coefficient every cycle, no stall on change
// - result is registered and also offered on a cascade output
// - narrow mode: two multipliers, independent or summed
// - result port is 74 bits, two 37-bit products side by side in independent mode
`timescale 1ns/100ps

module vpm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW:0] wr_r;
	logic [AW:0] rd_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// one spare pointer bit tells a full queue from an empty one
	wire [AW-1:0] wr_idx = wr_r[AW-1:0];
	wire [AW-1:0] rd_idx = rd_r[AW-1:0];
	wire full = (level == (AW+1)'(DEPTH));
	wire empty = (wr_r == rd_r);

	assign level = wr_r - rd_r;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_idx];

	// storage needs no reset; only the pointers decide what is valid
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_idx] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_r <= '0;
		end else if (push) begin
			wr_r <= wr_r + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_r <= '0;
		end else if (pop) begin
			rd_r <= rd_r + 1'b1;
		end
	end
endmodule

module vpm_slice import vpm_pkg::*; #(
	parameter int FIFO_DEPTH = `VPM_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [`VPM_AW-1:0] reg_addr,
	input wire logic [`VPM_DW-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [`VPM_DW-1:0] reg_rdata,
	input wire vpm_op_s op_data,
	input wire logic op_valid,
	output logic op_ready,
	input wire logic [`VPM_CASW-1:0] cascade_in,
	output logic [`VPM_RESW-1:0] result,
	output logic [`VPM_CASW-1:0] cascade_out,
	output logic res_valid,
	input wire logic res_ready
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	// coefficient slots are word aligned inside a 32-byte window per bank
	function automatic logic coef_hit(
		input logic [`VPM_AW-1:0] a,
		input logic [`VPM_AW-1:0] base
	);
		logic in_window;
		logic aligned;
		in_window = ((a & `VPM_COEF_MASK) == base);
		aligned = (a[1:0] == 2'b00);
		coef_hit = in_window && aligned;
	endfunction

	vpm_ctrl_s ctrl_r;
	logic [`VPM_HW-1:0] bank0_r [0:`VPM_NCOEF-1];
	logic [`VPM_NW-1:0] bank1_r [0:`VPM_NCOEF-1];
	logic [`VPM_DW-1:0] rdata_r;
	vpm_res_s res_r;
	logic res_valid_r;
	logic [15:0] count_r;
	logic [LW-1:0] fifo_level;
	vpm_op_s q;
	logic q_valid;
	logic advance;

	// input queue; drains only when the output register can take a word
	vpm_fifo #(
		.WIDTH($bits(vpm_op_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_data(op_data),
		.in_valid(op_valid),
		.in_ready(op_ready),
		.out_data(q),
		.out_valid(q_valid),
		.out_ready(advance),
		.level(fifo_level)
	);

	// register decode
	wire [2:0] coef_idx = reg_addr[4:2];
	wire hit_ctrl = (reg_addr == `VPM_OFF_CTRL);
	wire hit_status = (reg_addr == `VPM_OFF_STATUS);
	wire hit_coef0 = coef_hit(reg_addr, `VPM_OFF_COEF0);
	wire hit_coef1 = coef_hit(reg_addr, `VPM_OFF_COEF1);
	// level narrowed on purpose: deeper queues report only the low bits
	wire [4:0] st_level = 5'(fifo_level);
	wire [`VPM_DW-1:0] status_word = {count_r, 7'h0, res_valid_r, 3'h0, st_level};
	wire [`VPM_DW-1:0] ctrl_word = {28'h0, ctrl_r};
	wire [`VPM_DW-1:0] coef0_word = {5'h0, bank0_r[coef_idx]};
	wire [`VPM_DW-1:0] coef1_word = {14'h0, bank1_r[coef_idx]};
	// unmapped addresses read as zero
	wire [`VPM_DW-1:0] rd_mux =
		hit_ctrl ? ctrl_word :
		hit_status ? status_word :
		hit_coef0 ? coef0_word :
		hit_coef1 ? coef1_word : 32'h0;

	// control decode
	wire vpm_mode_e mode = ctrl_r.high_prec ? VPM_HIGH : VPM_NARROW;
	wire high_mode = (mode == VPM_HIGH);
	wire preadd_on = ctrl_r.preadd_en;
	wire sum_on = ctrl_r.sum_en && !high_mode;
	// cascade only joins the summed and high-precision paths; independent products have no common sum
	wire casc_on = ctrl_r.casc_en && (high_mode || sum_on);
	// index travels inside the word, so samples and coefficient never drift apart
	wire [`VPM_SELW-1:0] sel = q.sel;

	// coefficient pick in the same cycle as the operands, so an index change never stalls
	// bank0 low 18 bits serve lane 0 narrow, all 27 bits the single multiplier
	wire [`VPM_HW-1:0] coef_wide = bank0_r[sel];
	wire [`VPM_NW-1:0] coef_lane0 = coef_wide[`VPM_NW-1:0];
	wire [`VPM_NW-1:0] coef_lane1 = bank1_r[sel];

	// narrow lanes side by side, lane 0 at index 0
	wire [`VPM_NW-1:0] lane_a [0:1];
	wire [`VPM_NW-1:0] lane_b [0:1];
	wire [`VPM_NW-1:0] lane_c [0:1];
	wire signed [`VPM_NPW-1:0] lane_p [0:1];

	assign lane_a[0] = q.a0;
	assign lane_a[1] = q.a1;
	assign lane_b[0] = q.b0;
	assign lane_b[1] = q.b1;
	// lane 0 borrows the low bits of the wide bank
	assign lane_c[0] = coef_lane0;
	assign lane_c[1] = coef_lane1;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_lane
			// sign-extend to 19 bits so the sum of two samples never overflows
			wire signed [`VPM_SUMW-1:0] ax = {lane_a[g][`VPM_NW-1], lane_a[g]};
			wire signed [`VPM_SUMW-1:0] bx = {lane_b[g][`VPM_NW-1], lane_b[g]};
			wire signed [`VPM_SUMW-1:0] pre_sum = `VPM_SUMW'(ax + bx);
			// pre-adder off: the multiplier sees the first sample alone
			wire signed [`VPM_SUMW-1:0] mul_in = preadd_on ? pre_sum : ax;
			wire signed [`VPM_NW-1:0] coef = lane_c[g];
			wire signed [`VPM_NPW-1:0] prod = mul_in * coef;
			assign lane_p[g] = prod;
		end
	endgenerate

	// high-precision operands span lane 1 low bits above lane 0
	wire signed [`VPM_HW-1:0] ha = {q.a1[`VPM_HW-`VPM_NW-1:0], q.a0};
	wire signed [`VPM_HW-1:0] hb = {q.b1[`VPM_HW-`VPM_NW-1:0], q.b0};

	// one 27-bit adder, carry dropped: the fabric keeps both samples in range
	wire signed [`VPM_HW-1:0] hsum = `VPM_HW'(ha + hb);
	wire signed [`VPM_HW-1:0] hs = preadd_on ? hsum : ha;
	wire signed [`VPM_HW-1:0] ch = coef_wide;
	// no rounding or saturation anywhere: every product keeps all its bits
	wire signed [`VPM_HPW-1:0] hp = hs * ch;

	// summing arrangement keeps a guard bit so p0 + p1 never wraps
	wire signed [`VPM_NPW-1:0] p0 = lane_p[0];
	wire signed [`VPM_NPW-1:0] p1 = lane_p[1];

	wire signed [`VPM_NPW:0] p0x = {p0[`VPM_NPW-1], p0};
	wire signed [`VPM_NPW:0] p1x = {p1[`VPM_NPW-1], p1};
	wire signed [`VPM_NPW:0] psum = (`VPM_NPW+1)'(p0x + p1x);

	// widen every candidate to the result port before the final pick
	wire signed [`VPM_RESW-1:0] casc_w = `VPM_RESW'(signed'(cascade_in));
	wire signed [`VPM_RESW-1:0] casc_x = casc_on ? casc_w : '0;
	wire signed [`VPM_RESW-1:0] sum_x = `VPM_RESW'(psum);
	wire signed [`VPM_RESW-1:0] hp_x = `VPM_RESW'(hp);
	wire [`VPM_RESW-1:0] indep_x = {p1, p0};

	wire [`VPM_RESW-1:0] joined_x = high_mode ? hp_x : sum_x;
	wire [`VPM_RESW-1:0] chain_x = `VPM_RESW'(joined_x + casc_x);
	// independent mode shows both full products side by side
	wire [`VPM_RESW-1:0] res_nxt = (high_mode || sum_on) ? chain_x : indep_x;

	// a word moves on only when the output register is free or being emptied
	assign advance = !res_valid_r || res_ready;
	wire load = advance && q_valid;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= `VPM_CTRL_RST;
		end else if (reg_write && hit_ctrl) begin
			ctrl_r <= reg_wdata[3:0];
		end
	end

	// read data stand for one cycle only and are zero otherwise
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= reg_read ? rd_mux : 32'h0;
		end
	end

	// coefficients change only by software writes, never by the datapath
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < `VPM_NCOEF; i++) begin
				bank0_r[i] <= '0;
			end
		end else if (reg_write && hit_coef0) begin
			bank0_r[coef_idx] <= reg_wdata[`VPM_HW-1:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < `VPM_NCOEF; i++) begin
				bank1_r[i] <= '0;
			end
		end else if (reg_write && hit_coef1) begin
			bank1_r[coef_idx] <= reg_wdata[`VPM_NW-1:0];
		end
	end

	// output register holds while the consumer stalls
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			res_valid_r <= 1'b0;
		end else if (advance) begin
			res_valid_r <= q_valid;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			res_r <= '0;
		end else if (load) begin
			res_r.result <= res_nxt;
			res_r.cascade <= res_nxt[`VPM_CASW-1:0];
		end
	end

	// result count wraps at 16 bits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_r <= '0;
		end else if (load) begin
			count_r <= count_r + 16'h1;
		end
	end

	assign reg_rdata = rdata_r;
	assign result = res_r.result;
	assign cascade_out = res_r.cascade;
	assign res_valid = res_valid_r;
endmodule

// [vpm_slice_sva.sv]
`timescale 1ns/100ps
module vpm_slice_chk #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic op_valid,
	input wire logic op_ready,
	input wire logic [73:0] result,
	input wire logic [63:0] cascade_out,
	input wire logic res_valid,
	input wire logic res_ready
);
	logic [5:0] pend_r;
	wire acc = op_valid && op_ready;
	wire dlv = res_valid && res_ready;
	// words taken in but not yet handed on
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			pend_r <= 6'h0;
		else
			pend_r <= pend_r + 6'(acc) - 6'(dlv);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_CASC: assert property (res_valid |-> cascade_out == result[63:0]) else $error("cascade");
	AST_HOLD: assert property (res_valid && !res_ready |=> res_valid && $stable(result)) else $error("hold");
	AST_IDLE: assert property (acc && pend_r == 6'h0 |-> ##2 res_valid) else $error("latency");
	AST_LAT: assert property (acc && !res_valid |-> ##[2:18] res_valid) else $error("late");
	AST_RDY: assert property (pend_r < FIFO_DEPTH |-> op_ready) else $error("stall");
	AST_NOSPUR: assert property (res_valid |-> pend_r != 6'h0) else $error("spurious");
	AST_DROP: assert property (dlv && pend_r == 6'h1 |=> !res_valid) else $error("repeat");
	AST_BOUND: assert property (pend_r <= FIFO_DEPTH + 2) else $error("overfill");
	cover property (acc && res_valid && !res_ready);
	cover property (!op_ready);
	cover property (dlv && acc);
endmodule
bind vpm_slice vpm_slice_chk #(.FIFO_DEPTH(FIFO_DEPTH)) vpm_slice_chk_i (.*);
